// >>> pic_core.sv
// Programmable interrupt controller: registers, detection and comparator.
//
// Notes on behaviour
// - Global enable bit 10 gates pins and timers, never the NMI.
// - Control bits 11-12 choose how delivery clears the mask.
// - NMI and software interrupts never clear the mask.
// - Bit 13 fetches vectors ending 0010 from internal RAM.
// - Bit 14 picks debounce or fast sampling; expanded inputs always debounce.
// - Dedicated vector is programmed upper nibble then fixed 0010.
// - Map 0 and 1 hold pin nibbles ascending; map 2 the timers.
// - Pending and mask bits 0-7 are pins, 12-13 the timers.
// - An asserted dedicated or timer source latches its pending bit.
// - A zero mask bit stops its pending source requesting service.
// - Mask bit 0 masks pin 0, or all expanded requests.
// - Sources still latch pending bits during an atomic modify; only requests pause.
// - Atomic access to pending or mask never drives the bus lock.
// - Delivery clears the pending bit unless a level stays active.
// - Atomically set pending bits request like the pin would.
// - Loads return one cycle later; stores take effect at once.
// - Quick enable and disable take four cycles; control takes more.
// - Init loads control and maps; mask and pending kept.
// - Posted priority compared continuously; pins and timers told only if higher, the NMI always.
// - Control bits 0-1 pick dedicated, expanded or mixed mode.
// - Bits 2-9 pick level or falling edge; NMI always edge.
// - Debounce needs three stable low samples before acceptance.
`timescale 1ns/1ns
`default_nettype none
module pic_core
  import pic_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        cold_rst,
  // Interrupt pins, active low, and timer requests
  input  wire logic [7:0]  external_request_pins_n,
  input  wire logic        nmi_pin_n,
  input  wire logic        timer_request_0,
  input  wire logic        timer_request_1,
  // Initialisation load from the control table
  input  wire logic        init_load,
  input  wire logic [31:0] init_control,
  input  wire logic [31:0] init_map0,
  input  wire logic [31:0] init_map1,
  input  wire logic [31:0] init_tmrmap,
  // Register access from the core
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic        reg_atomic,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic [31:0] reg_wmask,
  output logic [31:0]      reg_rdata,
  output logic             reg_rvalid,
  output logic             bus_lock,
  // Quick enable operations
  input  wire logic        gie_op_start,
  input  wire logic [1:0]  gie_op,
  input  wire logic        gie_op_value,
  output logic             gie_op_done,
  output logic             gie_op_prev,
  // Comparator and delivery
  input  wire logic [4:0]  process_priority,
  output logic             irq_request,
  output logic [7:0]       irq_vector,
  output logic             irq_vector_cached,
  output logic             irq_nmi,
  input  wire logic        irq_ack,
  input  wire logic        sw_irq_ack
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [31:0] control_q;
  logic [31:0] source_vector_map_0_q;
  logic [31:0] source_vector_map_1_q;
  logic [31:0] timer_vector_map_q;
  logic [31:0] source_mask_q;
  logic [31:0] source_mask_d;
  logic [31:0] pending_requests_q;
  logic [31:0] pending_requests_d;
  logic        nmi_pend_q;
  logic        exp_act_q;
  logic [7:0]  exp_vec_q;
  logic        atomic_hold_q;
  logic [2:0]  gop_cnt_q;
  logic [1:0]  gop_q;
  logic        gop_val_q;

  function automatic logic [3:0] map_nibble(input logic [31:0] m,
                                            input int n);
    map_nibble = m[n*4 +: 4];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and pin sampling.

  pic_mode_t   mode;
  pic_mo_t     mo;
  logic        gie;
  logic        fast_debounce;
  logic [7:0]  ded_pins;
  logic [7:0]  pin_act;
  logic [7:0]  pin_act_prev_q;
  logic        nmi_act;
  logic        nmi_act_prev_q;
  logic [7:0]  pin_edge_det;

  assign mode          = pic_mode_t'(control_q[PIC_CTL_MODE_LSB +: 2]);
  assign mo            = pic_mo_t'(control_q[PIC_CTL_MO_LSB +: 2]);
  assign gie           = control_q[PIC_CTL_GIE];
  assign fast_debounce = control_q[PIC_CTL_SAMPLE];
  assign pin_edge_det  = control_q[PIC_CTL_DET_LSB +: 8];

  // Mixed mode keeps pins 5-7 dedicated; pins 0-4 form the vector.
  assign ded_pins = (mode == PIC_MODE_DEDICATED) ? 8'hFF :
                    (mode == PIC_MODE_MIXED)     ? 8'hE0 : 8'h00;

  for (genvar p = 0; p < 8; p++) begin : g_pin
    // Expanded pins always debounce; dedicated pins follow bit 14.
    pic_sampler #(.STAGES(PIC_DEBOUNCE_CNT)) u_smp (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .pin_n    (external_request_pins_n[p]),
      .debounce (fast_debounce | ~ded_pins[p]),
      .active   (pin_act[p])
    );
  end

  pic_sampler #(.STAGES(PIC_DEBOUNCE_CNT)) u_nmi (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .pin_n    (nmi_pin_n),
    .debounce (fast_debounce),
    .active   (nmi_act)
  );

  logic [1:0] tmr_sync1_q;
  logic [1:0] tmr_sync2_q;
  logic [1:0] tmr_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Source events and levels in pending-register layout.

  logic [31:0] src_event;
  logic [31:0] src_level;
  logic [7:0]  pin_event;

  for (genvar p = 0; p < 8; p++) begin : g_evt
    assign pin_event[p] = ded_pins[p] &
      (pin_edge_det[p] ? (pin_act[p] & ~pin_act_prev_q[p]) : pin_act[p]);
  end

  always_comb begin
    src_event = 32'h0;
    src_level = 32'h0;
    src_event[7:0] = pin_event;
    src_event[PIC_TIMER_REQUEST_0_BIT] = tmr_sync2_q[0] & ~tmr_prev_q[0];
    src_event[PIC_TIMER_REQUEST_1_BIT] = tmr_sync2_q[1] & ~tmr_prev_q[1];
    src_level[7:0] = ded_pins & ~pin_edge_det & pin_act;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparator and arbitration.

  logic [31:0] eligible;
  logic [9:0]  arb_req;
  logic [79:0] arb_vec;
  logic        arb_any;
  logic [3:0]  arb_idx;
  logic [7:0]  arb_vecw;
  logic [3:0]  arb_bit;
  logic        exp_ok;
  logic        take_exp;
  logic        hw_ok;
  logic        want_exp;

  // Expanded requests are gated by mask bit 0, dedicated ones by their own.
  assign eligible = pending_requests_q & source_mask_q & PIC_SRC_WMASK
                    & {18'h0, 2'b11, 4'h0, ded_pins};
  assign exp_ok   = exp_act_q & source_mask_q[0] & (mode != PIC_MODE_DEDICATED);

  for (genvar s = 0; s < 8; s++) begin : g_arb
    assign arb_req[s]        = eligible[s];
    assign arb_vec[s*8 +: 8] = {map_nibble(s < 4 ? source_vector_map_0_q
                                 : source_vector_map_1_q, s % 4),
                                PIC_VEC_LOW};
  end
  assign arb_req[8]      = eligible[PIC_TIMER_REQUEST_0_BIT];
  assign arb_req[9]      = eligible[PIC_TIMER_REQUEST_1_BIT];
  assign arb_vec[71:64]  = {timer_vector_map_q[PIC_TMAP_LSB +: 4],
                            PIC_VEC_LOW};
  assign arb_vec[79:72]  = {timer_vector_map_q[PIC_TMAP_LSB+4 +: 4],
                            PIC_VEC_LOW};

  pic_arbiter #(.NSRC(10)) u_arb (
    .req      (arb_req),
    .vec_flat (arb_vec),
    .any      (arb_any),
    .idx      (arb_idx),
    .vec      (arb_vecw)
  );

  assign arb_bit  = (arb_idx == 4'd8) ? 4'd12 :
                    (arb_idx == 4'd9) ? 4'd13 : arb_idx;
  assign take_exp = exp_ok && (!arb_any || exp_vec_q > arb_vecw);
  assign want_exp = gie && take_exp;
  // Priority is the vector's upper five bits.
  assign hw_ok    = gie && (take_exp || arb_any) &&
                    ((take_exp ? exp_vec_q[7:3] : arb_vecw[7:3])
                     > process_priority);

  assign irq_nmi           = nmi_pend_q;
  assign irq_request       = (nmi_pend_q || hw_ok) && !atomic_hold_q;
  assign irq_vector        = nmi_pend_q ? 8'hF8 :
                             (want_exp ? exp_vec_q : arb_vecw);
  assign irq_vector_cached = control_q[PIC_CTL_VCACHE] && !nmi_pend_q &&
                             (irq_vector[3:0] == PIC_VEC_LOW);

  ////////////////////////////////////////////////////////////////////////////
  // Pending and mask next state.

  logic        deliver_hw;
  logic        deliver_ded;
  logic        wr_pend;
  logic        wr_mask;
  logic [31:0] wmerge_pend;
  logic [31:0] wmerge_mask;
  logic [31:0] clr_pend;

  assign deliver_hw  = irq_ack && irq_request && !nmi_pend_q;
  assign deliver_ded = deliver_hw && !want_exp;
  assign wr_pend     = reg_wr && reg_addr == PIC_OFF_PENDING;
  assign wr_mask     = reg_wr && reg_addr == PIC_OFF_MASK;
  assign wmerge_pend = (pending_requests_q & ~reg_wmask) |
                       (reg_wdata & reg_wmask);
  assign wmerge_mask = (source_mask_q & ~reg_wmask) | (reg_wdata & reg_wmask);
  assign clr_pend    = deliver_ded ? (32'h1 << arb_bit) : 32'h0;

  always_comb begin
    pending_requests_d = wr_pend ? wmerge_pend : pending_requests_q;
    pending_requests_d = (pending_requests_d & ~clr_pend) | src_event
                         | src_level;
    source_mask_d = wr_mask ? wmerge_mask : source_mask_q;
    // Clearing the mask ignores NMI and software-acknowledged (sw_irq_ack) deliveries.
    if (deliver_hw && !sw_irq_ack) begin
      if ((mo == PIC_MO_CLR_BOTH) ||
          (mo == PIC_MO_CLR_DED && !want_exp) ||
          (mo == PIC_MO_CLR_EXP && want_exp)) begin
        source_mask_d = PIC_MASK_RST;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequential state.

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      source_mask_q  <= PIC_MASK_RST;
      nmi_pend_q     <= 1'b0;
      pin_act_prev_q <= 8'h00;
      nmi_act_prev_q <= 1'b0;
      tmr_sync1_q    <= 2'b00;
      tmr_sync2_q    <= 2'b00;
      tmr_prev_q     <= 2'b00;
      exp_act_q      <= 1'b0;
      exp_vec_q      <= 8'h00;
      atomic_hold_q  <= 1'b0;
    end else begin
      source_mask_q  <= source_mask_d & PIC_SRC_WMASK;
      pin_act_prev_q <= pin_act;
      nmi_act_prev_q <= nmi_act;
      tmr_sync1_q    <= {timer_request_1, timer_request_0};
      tmr_sync2_q    <= tmr_sync1_q;
      tmr_prev_q     <= tmr_sync2_q;
      nmi_pend_q     <= (nmi_act & ~nmi_act_prev_q) |
                        (nmi_pend_q & ~(irq_ack & irq_request));
      exp_act_q      <= |(pin_act & ~ded_pins);
      exp_vec_q      <= pin_act & ~ded_pins;
      // A locked modify holds requests for the one cycle after its read.
      atomic_hold_q  <= reg_rd && reg_atomic &&
                        (reg_addr == PIC_OFF_PENDING ||
                         reg_addr == PIC_OFF_MASK);
    end
  end

  // Pending has no reset value of its own; a cold reset clears it.
  always_ff @(posedge core_clk) begin
    if (cold_rst) begin
      pending_requests_q <= PIC_REG_RST;
    end else begin
      pending_requests_q <= pending_requests_d & PIC_SRC_WMASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, mapping and quick enable operations.

  logic ctl_wr;
  logic gop_fire;

  assign ctl_wr   = reg_wr && reg_addr == PIC_OFF_CONTROL;
  assign gop_fire = (gop_cnt_q == 3'd1);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      control_q             <= PIC_REG_RST;
      source_vector_map_0_q <= PIC_REG_RST;
      source_vector_map_1_q <= PIC_REG_RST;
      timer_vector_map_q    <= PIC_REG_RST;
      gop_cnt_q             <= 3'd0;
      gop_q                 <= PIC_GOP_NONE;
      gop_val_q             <= 1'b0;
      gie_op_prev           <= 1'b0;
    end else begin
      if (init_load) begin
        control_q             <= init_control & PIC_CTL_WMASK;
        source_vector_map_0_q <= init_map0 & PIC_MAP_WMASK;
        source_vector_map_1_q <= init_map1 & PIC_MAP_WMASK;
        timer_vector_map_q    <= init_tmrmap & PIC_TMAP_WMASK;
      end else begin
        if (ctl_wr) control_q <= reg_wdata & PIC_CTL_WMASK;
        if (reg_wr && reg_addr == PIC_OFF_MAP0)
          source_vector_map_0_q <= reg_wdata & PIC_MAP_WMASK;
        if (reg_wr && reg_addr == PIC_OFF_MAP1)
          source_vector_map_1_q <= reg_wdata & PIC_MAP_WMASK;
        if (reg_wr && reg_addr == PIC_OFF_TMRMAP)
          timer_vector_map_q <= reg_wdata & PIC_TMAP_WMASK;
        if (gop_fire && !ctl_wr) begin
          control_q[PIC_CTL_GIE] <= (gop_q == PIC_GOP_ENABLE) ? 1'b1 :
                                    (gop_q == PIC_GOP_DISABLE) ? 1'b0
                                    : gop_val_q;
        end
      end
      if (gop_cnt_q != 3'd0) begin
        gop_cnt_q <= gop_cnt_q - 3'd1;
      end else if (gie_op_start && gie_op != PIC_GOP_NONE) begin
        gop_q       <= gie_op;
        gop_val_q   <= gie_op_value;
        gie_op_prev <= gie;
        gop_cnt_q   <= (gie_op == PIC_GOP_CONTROL) ?
                       3'(PIC_CTL_CYCLES) : 3'(PIC_QUICK_CYCLES);
      end
    end
  end

  assign gie_op_done = gop_fire;

  ////////////////////////////////////////////////////////////////////////////
  // Read path with one cycle of latency.

  logic [31:0] rd_mux;

  assign rd_mux = (reg_addr == PIC_OFF_PENDING) ? pending_requests_q :
                  (reg_addr == PIC_OFF_MASK)    ? source_mask_q :
                  (reg_addr == PIC_OFF_CONTROL) ? control_q :
                  (reg_addr == PIC_OFF_MAP0)    ? source_vector_map_0_q :
                  (reg_addr == PIC_OFF_MAP1)    ? source_vector_map_1_q :
                  (reg_addr == PIC_OFF_TMRMAP)  ? timer_vector_map_q : 32'h0;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata  <= 32'h0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) reg_rdata <= rd_mux;
    end
  end

  // Atomic modifies of controller registers stay on chip.
  assign bus_lock = 1'b0;

endmodule : pic_core
`default_nettype wire

// >>> pic_pkg.sv
// Package of register offsets, field positions and encodings for the interrupt controller.
package pic_pkg;

  // Register byte offsets within the controller's memory-mapped window.
  localparam logic [7:0] PIC_OFF_PENDING  = 8'h00;
  localparam logic [7:0] PIC_OFF_MASK     = 8'h04;
  localparam logic [7:0] PIC_OFF_CONTROL  = 8'h10;
  localparam logic [7:0] PIC_OFF_MAP0     = 8'h20;
  localparam logic [7:0] PIC_OFF_MAP1     = 8'h24;
  localparam logic [7:0] PIC_OFF_TMRMAP   = 8'h28;

  // Control register fields.
  localparam int PIC_CTL_MODE_LSB   = 0;
  localparam int PIC_CTL_DET_LSB    = 2;
  localparam int PIC_CTL_GIE        = 10;
  localparam int PIC_CTL_MO_LSB     = 11;
  localparam int PIC_CTL_VCACHE     = 13;
  localparam int PIC_CTL_SAMPLE     = 14;
  localparam logic [31:0] PIC_CTL_WMASK  = 32'h0000_7FFF;
  localparam logic [31:0] PIC_MAP_WMASK  = 32'h0000_FFFF;
  localparam logic [31:0] PIC_TMAP_WMASK = 32'h00FF_0000;
  localparam logic [31:0] PIC_SRC_WMASK  = 32'h0000_30FF;
  localparam int PIC_TMAP_LSB       = 16;

  // Pending and mask bit positions of the timer sources.
  localparam int PIC_TIMER_REQUEST_0_BIT = 12;
  localparam int PIC_TIMER_REQUEST_1_BIT = 13;

  // Reset values.
  localparam logic [31:0] PIC_MASK_RST = 32'h0000_0000;
  localparam logic [31:0] PIC_REG_RST  = 32'h0000_0000;

  // Fixed low nibble of every dedicated vector and the cacheable pattern.
  localparam logic [3:0] PIC_VEC_LOW = 4'h2;

  // Debounce needs this many equal consecutive samples.
  localparam int PIC_DEBOUNCE_CNT = 3;

  // Cycles of the quick enable and disable operations and of the control operation.
  localparam int PIC_QUICK_CYCLES = 4;
  localparam int PIC_CTL_CYCLES   = 6;

  typedef enum logic [1:0] {
    PIC_MODE_DEDICATED = 2'b00,
    PIC_MODE_EXPANDED  = 2'b01,
    PIC_MODE_MIXED     = 2'b10,
    PIC_MODE_RSVD      = 2'b11
  } pic_mode_t;

  typedef enum logic [1:0] {
    PIC_MO_KEEP     = 2'b00,
    PIC_MO_CLR_DED  = 2'b01,
    PIC_MO_CLR_EXP  = 2'b10,
    PIC_MO_CLR_BOTH = 2'b11
  } pic_mo_t;

  typedef enum logic [1:0] {
    PIC_GOP_NONE    = 2'b00,
    PIC_GOP_DISABLE = 2'b01,
    PIC_GOP_ENABLE  = 2'b10,
    PIC_GOP_CONTROL = 2'b11
  } pic_gop_t;

endpackage : pic_pkg

// >>> pic_sampler.sv
// Pin synchroniser with fast or debounce sampling for one active-low input.
`timescale 1ns/1ns
`default_nettype none
module pic_sampler
  import pic_pkg::*;
#(
  parameter int STAGES = PIC_DEBOUNCE_CNT
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // Pin and options
  input  wire logic pin_n,
  input  wire logic debounce,
  // Filtered active level, high while the pin is held low
  output logic      active
);

  initial begin
    if (STAGES < 2) $error("pic_sampler needs at least two stages");
  end

  logic              sync1_q;
  logic              sync2_q;
  logic [STAGES-1:0] hist_q;
  logic              active_q;
  logic              active_d;

  // Fast mode takes the synchronised level, debounce needs a stable run.
  assign active_d = debounce ? ((&hist_q) ? 1'b1 :
                                (~|hist_q) ? 1'b0 : active_q)
                             : hist_q[0];
  assign active   = active_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q  <= 1'b0;
      sync2_q  <= 1'b0;
      hist_q   <= '0;
      active_q <= 1'b0;
    end else begin
      sync1_q  <= ~pin_n;
      sync2_q  <= sync1_q;
      hist_q   <= {hist_q[STAGES-2:0], sync2_q};
      active_q <= active_d;
    end
  end

endmodule : pic_sampler
`default_nettype wire

// >>> pic_arbiter.sv
// Priority selection of the highest unmasked pending source.
`timescale 1ns/1ns
`default_nettype none
module pic_arbiter
  import pic_pkg::*;
#(
  parameter int NSRC = 10
) (
  // Candidate sources and their vectors
  input  wire logic [NSRC-1:0]   req,
  input  wire logic [NSRC*8-1:0] vec_flat,
  // Winner
  output logic                   any,
  output logic [$clog2(NSRC)-1:0] idx,
  output logic [7:0]             vec
);

  initial begin
    if (NSRC < 2) $error("pic_arbiter needs at least two sources");
  end

  // Higher vector number means higher priority; ties go to the lower index.
  always_comb begin
    any = 1'b0;
    idx = '0;
    vec = 8'h00;
    for (int i = 0; i < NSRC; i++) begin
      if (req[i] && (!any || vec_flat[i*8 +: 8] > vec)) begin
        any = 1'b1;
        idx = i[$clog2(NSRC)-1:0];
        vec = vec_flat[i*8 +: 8];
      end
    end
  end

endmodule : pic_arbiter
`default_nettype wire

// >>> pic_core_sva.sv
// Port-level checker for the interrupt controller.
`timescale 1ns/1ns
`default_nettype none
module pic_core_chk
  import pic_pkg::*;
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       arst_n,
  // Register access
  input wire logic       reg_rd,
  input wire logic       reg_atomic,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_rvalid,
  input wire logic       bus_lock,
  // Quick enable operations
  input wire logic       gie_op_start,
  input wire logic [1:0] gie_op,
  input wire logic       gie_op_done,
  // Delivery
  input wire logic [4:0] process_priority,
  input wire logic       irq_request,
  input wire logic [7:0] irq_vector,
  input wire logic       irq_vector_cached,
  input wire logic       irq_nmi,
  input wire logic       irq_ack
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire atom_rd = reg_rd && reg_atomic
    && (reg_addr == PIC_OFF_PENDING || reg_addr == PIC_OFF_MASK);
  wire quick = gie_op_start
    && (gie_op == PIC_GOP_ENABLE || gie_op == PIC_GOP_DISABLE);
  property p_no_lock; bus_lock == 1'b0; endproperty
  a_no_lock: assert property (p_no_lock)
    else $error("bus lock driven");
  property p_rd_lat; reg_rd |=> reg_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer late");
  property p_rd_once; !reg_rd |=> !reg_rvalid; endproperty
  a_rd_once: assert property (p_rd_once)
    else $error("read answer without read");
  property p_atomic; atom_rd |=> !irq_request; endproperty
  a_atomic: assert property (p_atomic)
    else $error("request inside atomic modify");
  property p_quick; quick |=> !gie_op_done [*3] ##1 gie_op_done; endproperty
  a_quick: assert property (p_quick)
    else $error("quick enable op not four cycles");
  property p_ctlop;
    gie_op_start && gie_op == PIC_GOP_CONTROL |=> !gie_op_done [*5]
      ##1 gie_op_done;
  endproperty
  a_ctlop: assert property (p_ctlop)
    else $error("control op length wrong");
  property p_prio;
    irq_request && !irq_nmi |-> irq_vector[7:3] > process_priority;
  endproperty
  a_prio: assert property (p_prio)
    else $error("request not above process priority");
  property p_cache; irq_vector_cached |-> irq_vector[3:0] == PIC_VEC_LOW;
  endproperty
  a_cache: assert property (p_cache)
    else $error("cached vector not ending 0010");
  c_atomic: cover property (atom_rd);
  c_ack: cover property (irq_request && irq_ack);
  c_quick: cover property (quick ##4 gie_op_done);
endmodule : pic_core_chk
bind pic_core pic_core_chk u_chk (.*);
`default_nettype wire

// >>> pic_src_model.sv
// Model of the interrupt sources and the core's acceptance of a delivery.
`timescale 1ns/1ns
`default_nettype none
module pic_src_model (
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] pin_on,
  input  wire logic       nmi_on,
  input  wire logic [1:0] tmr_on,
  input  wire logic       ack_arm,
  input  wire logic       irq_request,
  output logic [7:0]      pins_n,
  output logic            nmi_n,
  output logic [1:0]      tmr,
  output logic            irq_ack
);
  logic armed_q;
  // Pins idle high on their pull-ups; one ack per arming avoids double takes.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pins_n  <= 8'hFF;
      nmi_n   <= 1'b1;
      tmr     <= 2'h0;
      irq_ack <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      pins_n  <= ~pin_on;
      nmi_n   <= ~nmi_on;
      tmr     <= tmr_on;
      irq_ack <= armed_q && irq_request && !irq_ack;
      armed_q <= ack_arm || (armed_q && !(irq_request && !irq_ack));
    end
  end
endmodule : pic_src_model
`default_nettype wire

// >>> programmable_interrupt_controller_tb.sv
// Self-checking bench for the interrupt controller.
`timescale 1ns/1ns
`default_nettype none
module programmable_interrupt_controller_tb;
  import pic_pkg::*;
  logic core_clk = 0, arst_n = 0, cold_rst = 0, init_load = 0;
  logic reg_rd = 0, reg_wr = 0, reg_atomic = 0, gie_op_start = 0;
  logic gie_op_value = 1, sw_irq_ack = 0, ack_arm = 0, nmi_on = 0, nmi_n;
  logic [7:0] reg_addr = 0, pin_on = 0, pins_n, irq_vector;
  logic [31:0] reg_wdata = 0, reg_wmask = 0, reg_rdata;
  logic [1:0] gie_op = 0, tmr_on = 0, tmr;
  logic [4:0] process_priority = 0;
  logic reg_rvalid, bus_lock, gie_op_done, gie_op_prev, irq_request;
  logic irq_vector_cached, irq_nmi, irq_ack;
  int mismatches = 0;
  int n_tests = 0;
  pic_core dut (.*, .external_request_pins_n(pins_n), .nmi_pin_n(nmi_n),
    .timer_request_0(tmr[0]), .timer_request_1(tmr[1]),
    .init_control('1), .init_map0('1), .init_map1('1), .init_tmrmap('1));
  pic_src_model u_src (.*);
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic final_report();
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [31:0] m = '1);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wmask <= m;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e, string nm, logic at = 0);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_atomic <= at;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_atomic <= 1'b0;
    #1;
    chk(nm, reg_rdata, e);
  endtask : rd
  // Waits a bounded span for a delivery request or an op completion.
  task automatic settle(bit op);
    for (int i = 0; i < 40; i++) begin
      @(posedge core_clk);
      #1;
      if ((op ? gie_op_done : irq_request) === 1'b1) break;
    end
  endtask : settle
  task automatic gie(logic [1:0] op);
    @(posedge core_clk);
    gie_op_start <= 1'b1;
    gie_op <= op;
    @(posedge core_clk);
    gie_op_start <= 1'b0;
    settle(1);
    repeat (2) @(posedge core_clk);
    #1;
  endtask : gie
  task automatic take(bit sw);
    @(posedge core_clk);
    ack_arm <= 1'b1;
    sw_irq_ack <= sw;
    @(posedge core_clk);
    ack_arm <= 1'b0;
    repeat (4) @(posedge core_clk);
    sw_irq_ack <= 1'b0;
  endtask : take
  task automatic t_regs();
    rd(PIC_OFF_MASK, 32'h0, "mask_rst");
    @(posedge core_clk);
    init_load <= 1'b1;
    @(posedge core_clk);
    init_load <= 1'b0;
    rd(PIC_OFF_CONTROL, 32'h0000_7FFF, "ctl_init");
    rd(PIC_OFF_MAP1, 32'h0000_FFFF, "map1_init");
    rd(PIC_OFF_TMRMAP, 32'h00FF_0000, "tmap_init");
    wr(PIC_OFF_CONTROL, 32'h0);
    wr(PIC_OFF_MASK, 32'hFFFF_FFFF);
    rd(PIC_OFF_MASK, 32'h0000_30FF, "mask_bits");
    wr(8'h40, 32'h1234_5678);
    rd(8'h40, 32'h0, "unmapped");
    wr(PIC_OFF_MASK, 32'h0);
  endtask : t_regs
  task automatic t_edge();
    wr(PIC_OFF_MAP0, 32'h0000_0065);
    wr(PIC_OFF_CONTROL, 32'h0000_0C08);
    pin_on <= 8'h02;
    repeat (12) @(posedge core_clk);
    rd(PIC_OFF_PENDING, 32'h2, "pend_pin1");
    chk("req_masked", 32'(irq_request), 32'h0);
    wr(PIC_OFF_MASK, 32'h2);
    settle(0);
    chk("vec_pin1", 32'(irq_vector), 32'h62);
    take(0);
    pin_on <= 8'h00;
    rd(PIC_OFF_MASK, 32'h0, "mask_clr_ded");
    rd(PIC_OFF_PENDING, 32'h0, "pend_edge_clr");
  endtask : t_edge
  task automatic t_level();
    wr(PIC_OFF_CONTROL, 32'h0000_0400);
    wr(PIC_OFF_MASK, 32'h1);
    pin_on <= 8'h01;
    settle(0);
    chk("vec_pin0", 32'(irq_vector), 32'h52);
    take(0);
    rd(PIC_OFF_PENDING, 32'h1, "pend_level");
    rd(PIC_OFF_MASK, 32'h1, "mask_keep");
    pin_on <= 8'h00;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b0;
    @(posedge core_clk);
    arst_n <= 1'b1;
    rd(PIC_OFF_PENDING, 32'h1, "pend_warm");
    rd(PIC_OFF_MASK, 32'h0, "mask_warm");
    wr(PIC_OFF_PENDING, 32'h0, 32'h1);
    rd(PIC_OFF_PENDING, 32'h0, "pend_sw_clr");
  endtask : t_level
  task automatic t_timer();
    wr(PIC_OFF_TMRMAP, 32'h0007_0000);
    wr(PIC_OFF_CONTROL, 32'h0000_3C00);
    wr(PIC_OFF_MASK, 32'h1000);
    process_priority <= 5'd14;
    tmr_on <= 2'h1;
    repeat (8) @(posedge core_clk);
    #1;
    chk("req_equal_prio", 32'(irq_request), 32'h0);
    rd(PIC_OFF_PENDING, 32'h1000, "pend_timer_request_0", 1);
    process_priority <= 5'd13;
    settle(0);
    chk("vec_timer_request_0", 32'(irq_vector), 32'h72);
    chk("vec_cached", 32'(irq_vector_cached), 32'h1);
    gie(PIC_GOP_DISABLE);
    chk("req_gie_off", 32'(irq_request), 32'h0);
    gie(PIC_GOP_ENABLE);
    chk("req_gie_on", 32'(irq_request), 32'h1);
    gie(PIC_GOP_DISABLE);
    gie(PIC_GOP_CONTROL);
    chk("gie_prev", 32'(gie_op_prev), 32'h0);
    nmi_on <= 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    chk("nmi_vec", 32'(irq_vector), 32'hF8);
    nmi_on <= 1'b0;
    take(0);
    #1;
    chk("nmi_done", 32'(irq_nmi), 32'h0);
    tmr_on <= 2'h0;
    take(1);
    rd(PIC_OFF_MASK, 32'h1000, "mask_sw");
    rd(PIC_OFF_PENDING, 32'h0, "pend_tmr_clr");
    wr(PIC_OFF_PENDING, 32'h1000, 32'h1000);
    settle(0);
    chk("req_posted", 32'(irq_request), 32'h1);
    take(0);
    rd(PIC_OFF_MASK, 32'h0, "mask_clr_both");
    wr(PIC_OFF_CONTROL, 32'h0000_1401);
    wr(PIC_OFF_MASK, 32'h1);
    pin_on <= 8'h93;
    settle(0);
    chk("vec_exp", 32'(irq_vector), 32'h93);
    take(0);
    rd(PIC_OFF_MASK, 32'h0, "mask_clr_exp");
  endtask : t_timer
  initial begin
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    cold_rst <= 1'b1;
    @(posedge core_clk);
    cold_rst <= 1'b0;
    t_regs();
    t_edge();
    t_level();
    t_timer();
    final_report();
  end
  initial begin
    #50000;
    mismatches++;
    final_report();
  end
endmodule : programmable_interrupt_controller_tb
`default_nettype wire
